// ==== tb/tam_core_sva.sv ====
// Purpose: Port checks for the thermal alarm core
// Assumes: One clock, async active-low reset
// Notes:   Pointer and polarity are shadowed from host traffic
module tam_core_sva (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_ptr_stb,
  input wire logic [7:0]  i_ptr_byte,
  input wire logic        i_wr_stb,
  input wire logic [15:0] i_wr_data,
  input wire logic        i_rd_stb,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic        i_temp_valid,
  input wire logic [15:0] i_temp_data,
  input wire logic        o_power_down,
  input wire logic        o_alarm_out,
  input wire logic        o_alarm_oe,
  input wire logic        o_alarm_asserted_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ptr_q;
  logic [7:0] rd_ptr_q;
  logic       pol_q;

  // Shadows; polarity is never frozen by a lock
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ptr_q    <= 8'h00;
      rd_ptr_q <= 8'h00;
      pol_q    <= 1'b0;
    end
    else
    begin
      if (i_ptr_stb)
        ptr_q <= i_ptr_byte;
      if (i_rd_stb)
        rd_ptr_q <= ptr_q;
      if (i_wr_stb && ptr_q == 8'h01)
        pol_q <= i_wr_data[1];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_pol_settled; $stable(pol_q) [*3]; endsequence
  sequence s_quiet_down; (o_power_down && !i_wr_stb) [*4]; endsequence
  property p_rd_pulse; o_rd_valid == $past(i_rd_stb); endproperty
  property p_rd_hold; !$past(i_rd_stb) |-> $stable(o_rd_data); endproperty
  property p_ctrl_read; o_rd_valid && rd_ptr_q == 8'h01 |-> o_rd_data[15:11] == 5'h00 && !o_rd_data[5]; endproperty
  property p_open_drain; o_alarm_out == 1'b0; endproperty
  property p_pin_level;
    s_pol_settled |-> (pol_q ? !(o_alarm_asserted_flag && o_alarm_oe) : o_alarm_oe == o_alarm_asserted_flag);
  endproperty
  property p_pd_cause; !$stable(o_power_down) |-> $past(i_wr_stb); endproperty
  property p_pd_freeze; s_quiet_down |-> $stable(o_alarm_asserted_flag); endproperty
  property p_flag_cause;
    !$stable(o_alarm_asserted_flag) |-> $past(i_temp_valid, 2) || $past(i_temp_valid, 3)
      || $past(i_wr_stb) || $past(i_wr_stb, 2) || $past(i_wr_stb, 3);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read valid not one cycle after read strobe");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("reserved or release bit read nonzero");
  a_open_drain: assert property (p_open_drain)
    else $error("alarm pin data not low");
  a_pin_level: assert property (p_pin_level)
    else $error("alarm pin level disagrees with flag");
  a_pd_cause: assert property (p_pd_cause)
    else $error("power down moved without a write");
  a_pd_freeze: assert property (p_pd_freeze)
    else $error("alarm moved in power down");
  a_flag_cause: assert property (p_flag_cause)
    else $error("alarm moved without sample or write");
endmodule

bind tam_core tam_core_sva u_sva (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ptr_stb(i_ptr_stb),
  .i_ptr_byte(i_ptr_byte), .i_wr_stb(i_wr_stb), .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_temp_valid(i_temp_valid),
  .i_temp_data(i_temp_data), .o_power_down(o_power_down), .o_alarm_out(o_alarm_out),
  .o_alarm_oe(o_alarm_oe), .o_alarm_asserted_flag(o_alarm_asserted_flag));

// ==== tb/tam_host_model.sv ====
// Purpose: Host side of the register port
// Assumes: Strobes change 10 ns after the rising edge
// Notes:   Released data shows its inverse, never the old value
module tam_host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output logic             o_ptr_stb,
  output logic [7:0]       o_ptr_byte,
  output logic             o_wr_stb,
  output logic [15:0]      o_wr_data,
  output logic             o_rd_stb
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    o_ptr_stb  = 1'b0;
    o_ptr_byte = 8'h00;
    o_wr_stb   = 1'b0;
    o_wr_data  = 16'h0000;
    o_rd_stb   = 1'b0;
  end

  // Pointer byte always goes first
  task automatic point(input logic [7:0] p);
    @(posedge i_clk);
    #10 o_ptr_stb = 1'b1;
    o_ptr_byte = p;
    @(posedge i_clk);
    #10 o_ptr_stb = 1'b0;
    o_ptr_byte = ~p;
  endtask

  // Whole word, one strobe
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    point(p);
    o_wr_stb = 1'b1;
    o_wr_data = d;
    @(posedge i_clk);
    #10 o_wr_stb = 1'b0;
    o_wr_data = ~d;
  endtask

  // Answer is due one edge after the strobe
  task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic v);
    point(p);
    o_rd_stb = 1'b1;
    @(posedge i_clk);
    #10 o_rd_stb = 1'b0;
    v = i_rd_valid;
    d = i_rd_data;
  endtask
endmodule

// ==== tb/thermal_alarm_config_tb.sv ====
// Purpose: Self-checking bench for the thermal alarm core
// Assumes: 100 ns clock, host model drives the register port
// Notes:   Alarm checked four edges after each sample
`include "tam_map.vh"
module thermal_alarm_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] p; logic [15:0] w; logic [15:0] e;} tam_row_t;
  logic        i_clk, i_reset_n, ptr_stb, wr_stb, rd_stb, rd_valid, temp_valid, pd, a_out, a_oe, flag;
  logic [7:0]  ptr_byte;
  logic [15:0] wr_data, rd_data, temp_data;
  int          num_errors = 0;
  int          compares = 0;
  int          hq [4] = '{0, 6, 12, 24};
  tam_row_t    rows [6] = '{'{8'h01, 16'hF800, 16'h0000}, '{8'h01, 16'h062F, 16'h060F},
    '{8'h02, 16'hFFFF, 16'h1FFC}, '{8'h03, 16'h1234, 16'h1234}, '{8'h07, 16'hFFFF, 16'h0000},
    '{8'h00, 16'h5555, 16'h0000}};

  tam_core dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ptr_stb(ptr_stb), .i_ptr_byte(ptr_byte),
    .i_wr_stb(wr_stb), .i_wr_data(wr_data), .i_rd_stb(rd_stb), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .i_temp_valid(temp_valid), .i_temp_data(temp_data), .o_power_down(pd), .o_alarm_out(a_out),
    .o_alarm_oe(a_oe), .o_alarm_asserted_flag(flag));
  tam_host_model host (.i_clk(i_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_ptr_stb(ptr_stb),
    .o_ptr_byte(ptr_byte), .o_wr_stb(wr_stb), .o_wr_data(wr_data), .o_rd_stb(rd_stb));

  // Clock
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset();
    i_reset_n = 1'b0;
    repeat (8) @(posedge i_clk);
    #10 i_reset_n = 1'b1;
  endtask

  // Quarter degrees to limit coding, unused bits kept zero
  function automatic logic [15:0] tq(input int q);
    return 16'(q * 4) & 16'h1FFF;
  endfunction

  task automatic rchk(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    host.rd(p, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, e);
  endtask

  task automatic temp(input logic [15:0] t, input logic e);
    @(posedge i_clk);
    #10 temp_valid = 1'b1;
    temp_data = t;
    @(posedge i_clk);
    #10 temp_valid = 1'b0;
    temp_data = ~t;
    repeat (3) @(posedge i_clk);
    #10 check({15'h0000, flag}, {15'h0000, e});
  endtask

  // Watchdog, about fifteen times the expected run
  initial
  begin
    #500us;
    num_errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    temp_valid = 1'b0;
    temp_data = 16'h0000;
    do_reset();
    rchk(`TAM_PTR_CTRL, 16'h0000);
    foreach (rows[i])
    begin
      host.wr(rows[i].p, rows[i].w);
      rchk(rows[i].p, rows[i].e);
    end
    host.wr(`TAM_PTR_UPPER, tq(100));
    host.wr(`TAM_PTR_LOWER, 16'h0000);
    host.wr(`TAM_PTR_CRIT, tq(200));
    for (int h = 0; h < 4; h++)
    begin
      host.wr(`TAM_PTR_CTRL, {5'h00, 2'(h), 9'h008});
      temp(tq(100) | 16'h0003, 1'b0);
      temp(tq(101), 1'b1);
      temp(tq(101 - hq[h]), 1'b1);
      temp(tq(100 - hq[h]), 1'b0);
    end
    host.wr(`TAM_PTR_CTRL, 16'h0208);
    temp(tq(-1), 1'b0);
    temp(tq(-7), 1'b1);
    temp(tq(-1), 1'b1);
    temp(tq(0), 1'b0);
    temp(tq(-7), 1'b1);
    check({15'h0000, a_oe}, 16'h0001);
    check({15'h0000, a_out}, 16'h0000);
    host.wr(`TAM_PTR_CTRL, 16'h022A);
    rchk(`TAM_PTR_CTRL, 16'h021A);
    check({15'h0000, a_oe}, 16'h0000);
    host.wr(`TAM_PTR_CTRL, 16'h020C);
    rchk(`TAM_PTR_CTRL, 16'h020C);
    temp(tq(201), 1'b1);
    temp(tq(195), 1'b1);
    temp(tq(194), 1'b0);
    host.wr(`TAM_PTR_CTRL, 16'h0200);
    rchk(`TAM_PTR_CTRL, 16'h0200);
    host.wr(`TAM_PTR_CTRL, 16'h0308);
    temp(tq(50), 1'b1);
    check({15'h0000, pd}, 16'h0001);
    rchk(`TAM_PTR_CTRL, 16'h0318);
    host.wr(`TAM_PTR_CTRL, 16'h0208);
    temp(tq(50), 1'b0);
    host.wr(`TAM_PTR_CTRL, 16'h0009);
    host.wr(`TAM_PTR_CTRL, 16'h0029);
    rchk(`TAM_PTR_CTRL, 16'h0009);
    temp(tq(101), 1'b1);
    host.wr(`TAM_PTR_CTRL, 16'h0029);
    temp(tq(102), 1'b0);
    host.wr(`TAM_PTR_CTRL, 16'h0008);
    temp(tq(103), 1'b1);
    temp(tq(50), 1'b0);
    host.wr(`TAM_PTR_CTRL, 16'h0009);
    host.wr(`TAM_PTR_CTRL, 16'h0029);
    temp(tq(101), 1'b1);
    host.wr(`TAM_PTR_CTRL, 16'h0029);
    rchk(`TAM_PTR_CTRL, 16'h0009);
    host.wr(`TAM_PTR_CTRL, 16'h0100);
    host.wr(`TAM_PTR_CTRL, 16'h0140);
    host.wr(`TAM_PTR_CTRL, 16'h0040);
    rchk(`TAM_PTR_CTRL, 16'h0040);
    host.wr(`TAM_PTR_CTRL, 16'h074E);
    rchk(`TAM_PTR_CTRL, 16'h0042);
    host.wr(`TAM_PTR_UPPER, 16'h0200);
    rchk(`TAM_PTR_UPPER, tq(100));
    host.wr(`TAM_PTR_CTRL, 16'h0080);
    rchk(`TAM_PTR_CTRL, 16'h00C0);
    host.wr(`TAM_PTR_CRIT, 16'h0100);
    rchk(`TAM_PTR_CRIT, tq(200));
    do_reset();
    check({14'h0000, a_oe, flag}, 16'h0000);
    rchk(`TAM_PTR_UPPER, 16'h0000);
    host.wr(`TAM_PTR_CTRL, 16'h0080);
    host.wr(`TAM_PTR_CTRL, 16'h0604);
    rchk(`TAM_PTR_CTRL, 16'h0084);
    host.wr(`TAM_PTR_LOWER, 16'h0100);
    rchk(`TAM_PTR_LOWER, 16'h0100);
    final_report();
  end
endmodule

// ==== verilog/tam_core.v ====
// Purpose: Thermal alarm control, limit registers and alarm pin
// Assumes: Bus engine hands over pointer bytes and whole data words
// Notes:   Temperature samples come from on-chip logic, same clock
// Notes on behaviour
// - Control bits 15 to 11 read zero and ignore writes.
// - Bits 10:9 pick hysteresis none, 1.5, 3 or 6 degrees.
// - Hysteresis only on falling side; also for alarm pin.
// - Hysteresis field frozen while either lock bit is set.
// - Power-down stops sampling, so comparator flags hold; bus still answers.
// - Lock refuses setting power-down; clearing always allowed.
// - Bit 7 locks critical limit, sticky until power-on reset.
// - Bit 6 locks window limits, sticky until power-on reset.
// - Bit 5 releases latched alarm in interrupt mode, reads zero.
// - Bit 4 reads one while alarm is asserted.
// - Bit 3 enables the alarm pin; frozen under either lock.
// - Bit 2 selects critical-only alarm; frozen under window lock.
// - Bit 1 picks asserted pin level, low by default.
// - Bit 0 picks comparator or interrupt mode.
// - Temperatures are two's complement, bits 12 to 2 valid.
// - Comparisons use only bits 12 to 2 of the temperature.
// - Upper limit trips above, re-signals at limit minus hyst.
// - Lower trips below limit minus hyst, re-signals at limit.
// - Control register is 16 bits at pointer 01, resets zero.
// - Critical trip holds until at or below limit minus hyst.
// - Pointer byte selects register; writes carry a whole word.
`include "tam_map.vh"

module tam_core (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_ptr_stb,
  input  wire [7:0]  i_ptr_byte,
  input  wire        i_wr_stb,
  input  wire [15:0] i_wr_data,
  input  wire        i_rd_stb,
  output wire [15:0] o_rd_data,
  output wire        o_rd_valid,
  input  wire        i_temp_valid,
  input  wire [15:0] i_temp_data,
  output wire        o_power_down,
  output wire        o_alarm_out,
  output wire        o_alarm_oe,
  output wire        o_alarm_asserted_flag
);

  // Pointer and register storage
  reg  [7:0]  ptr_q;
  reg  [1:0]  hyst_q;
  reg         power_down_q;
  reg         critical_limit_lock_q;
  reg         win_lock_q;
  reg         alarm_en_q;
  reg         critical_only_select_q;
  reg         alarm_polarity_q;
  reg         irq_mode_q;
  reg  [10:0] upper_q;
  reg  [10:0] lower_q;
  reg  [10:0] crit_q;

  // Alarm state
  reg         irq_q;
  reg         cond_q;
  reg         asserted_q;
  reg         pin_q;
  reg         sample_q;

  // Read path
  reg  [15:0] rdata_q;
  reg         rvalid_q;
  reg  [15:0] rdata_d;

  // Decoded strobes
  wire        any_lock;
  wire        wr_ctrl;
  wire        wr_upper;
  wire        wr_lower;
  wire        wr_crit;
  wire        release_pulse;
  wire        hyst_we;
  wire        pd_we;
  wire        alarm_en_we;
  wire        crit_only_we;
  wire        sample;
  wire [10:0] temp_q4;
  reg  [12:0] hyst_val;
  wire        upper_flag;
  wire        lower_flag;
  wire        crit_flag;
  wire        cond_d;
  wire        event_d;
  wire        asserted_d;
  wire        pin_d;
  wire [15:0] ctrl_view;

  // Pointer byte arrives first in every transfer
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ptr_q <= `TAM_PTR_RESET;
    else if (i_ptr_stb)
      ptr_q <= i_ptr_byte;
  end

  // Word writes land in the register the pointer selects
  assign wr_ctrl  = i_wr_stb && (ptr_q == `TAM_PTR_CTRL);
  assign wr_upper = i_wr_stb && (ptr_q == `TAM_PTR_UPPER);
  assign wr_lower = i_wr_stb && (ptr_q == `TAM_PTR_LOWER);
  assign wr_crit  = i_wr_stb && (ptr_q == `TAM_PTR_CRIT);

  // Locks are judged on the value held before this write
  assign any_lock = critical_limit_lock_q | win_lock_q;

  // Per-field write enables; a lock refuses a field, never the whole word
  assign hyst_we      = wr_ctrl && !any_lock;
  assign pd_we        = wr_ctrl && (!i_wr_data[`TAM_POWER_DOWN] || !any_lock);
  assign alarm_en_we  = wr_ctrl && !any_lock;
  assign crit_only_we = wr_ctrl && !win_lock_q;

  // Locks only ever set; a zero write leaves them until power-on reset
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      critical_limit_lock_q <= 1'b0;
      win_lock_q            <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      critical_limit_lock_q <= critical_limit_lock_q | i_wr_data[`TAM_CRIT_LOCK];
      win_lock_q            <= win_lock_q | i_wr_data[`TAM_WIN_LOCK];
    end
  end

  // Control fields; reserved bits 15:11 have no storage
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hyst_q                 <= 2'b00;
      power_down_q           <= 1'b0;
      alarm_en_q             <= 1'b0;
      critical_only_select_q <= 1'b0;
      alarm_polarity_q       <= 1'b0;
      irq_mode_q             <= 1'b0;
    end
    else
    begin
      if (hyst_we)
        hyst_q <= i_wr_data[`TAM_HYST_HI:`TAM_HYST_LO];
      // Clearing power-down is never refused
      if (pd_we)
        power_down_q <= i_wr_data[`TAM_POWER_DOWN];
      if (alarm_en_we)
        alarm_en_q <= i_wr_data[`TAM_ALARM_EN];
      if (crit_only_we)
        critical_only_select_q <= i_wr_data[`TAM_CRIT_ONLY];
      // Polarity and mode stay writable under either lock
      if (wr_ctrl)
      begin
        alarm_polarity_q <= i_wr_data[`TAM_POLARITY];
        irq_mode_q       <= i_wr_data[`TAM_IRQ_MODE];
      end
    end
  end

  // Release is a write-only strobe, dropped in comparator mode
  assign release_pulse = wr_ctrl && i_wr_data[`TAM_RELEASE] && irq_mode_q;

  // Limit registers keep bits 12:2 only; others read zero
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      upper_q <= `TAM_LIMIT_RESET;
      lower_q <= `TAM_LIMIT_RESET;
      crit_q  <= `TAM_LIMIT_RESET;
    end
    else
    begin
      if (wr_upper && !win_lock_q)
        upper_q <= i_wr_data[`TAM_LIM_HI:`TAM_LIM_LO];
      if (wr_lower && !win_lock_q)
        lower_q <= i_wr_data[`TAM_LIM_HI:`TAM_LIM_LO];
      if (wr_crit && !critical_limit_lock_q)
        crit_q <= i_wr_data[`TAM_LIM_HI:`TAM_LIM_LO];
    end
  end

  // Hysteresis code to quarter-degree magnitude
  always @*
  begin
    case (hyst_q)
      2'b00:   hyst_val = `TAM_HYST_NONE;
      2'b01:   hyst_val = `TAM_HYST_1P5;
      2'b10:   hyst_val = `TAM_HYST_3;
      2'b11:   hyst_val = `TAM_HYST_6;
      default: hyst_val = `TAM_HYST_NONE;
    endcase
  end

  // Finer bits below bit 2 never reach the comparators
  assign temp_q4 = i_temp_data[`TAM_LIM_HI:`TAM_LIM_LO];

  // No new samples in power-down, so every comparator flag freezes
  assign sample = i_temp_valid && !power_down_q;

  // Three comparators share one structure
  tam_hyst_cmp #(
    .BELOW (0)
  ) u_upper (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_sample  (sample),
    .i_temp    (temp_q4),
    .i_limit   (upper_q),
    .i_hyst    (hyst_val),
    .o_flag    (upper_flag)
  );

  tam_hyst_cmp #(
    .BELOW (1)
  ) u_lower (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_sample  (sample),
    .i_temp    (temp_q4),
    .i_limit   (lower_q),
    .i_hyst    (hyst_val),
    .o_flag    (lower_flag)
  );

  tam_hyst_cmp #(
    .BELOW (0)
  ) u_crit (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_sample  (sample),
    .i_temp    (temp_q4),
    .i_limit   (crit_q),
    .i_hyst    (hyst_val),
    .o_flag    (crit_flag)
  );

  // Qualifying condition; window flags masked in critical-only mode
  assign cond_d = crit_flag | (!critical_only_select_q & (upper_flag | lower_flag));

  // Comparator flags settle one cycle after the sample strobe
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sample_q <= 1'b0;
      cond_q   <= 1'b0;
    end
    else
    begin
      sample_q <= sample;
      cond_q   <= cond_d;
    end
  end

  // A crossing is a change of the qualifying condition in the cycle after a sample
  assign event_d = sample_q && (cond_d != cond_q);

  // Interrupt latch; a new crossing beats a release in the same cycle
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      irq_q <= 1'b0;
    else if (event_d)
      irq_q <= 1'b1;
    else if (release_pulse)
      irq_q <= 1'b0;
  end

  // Level in comparator mode, latch in interrupt mode, gated by enable
  assign asserted_d = alarm_en_q & (irq_mode_q ? irq_q : cond_d);

  // Active level from polarity bit, idle is its inverse
  assign pin_d = asserted_d ? alarm_polarity_q : !alarm_polarity_q;

  // Pin is registered so it never glitches on mode writes
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      asserted_q <= 1'b0;
      pin_q      <= 1'b1;
    end
    else
    begin
      asserted_q <= asserted_d;
      pin_q      <= pin_d;
    end
  end

  // Open-drain pin: drive only the low level, pull-up gives high
  assign o_alarm_out = 1'b0;
  assign o_alarm_oe  = !pin_q;
  assign o_alarm_asserted_flag = asserted_q;
  assign o_power_down = power_down_q;

  // Control as read back; release reads zero, reserved reads zero
  assign ctrl_view = {5'b0_0000,
                      hyst_q,
                      power_down_q,
                      critical_limit_lock_q,
                      win_lock_q,
                      1'b0,
                      asserted_q,
                      alarm_en_q,
                      critical_only_select_q,
                      alarm_polarity_q,
                      irq_mode_q};

  // Read mux; pointers this block does not own read zero
  always @*
  begin
    case (ptr_q)
      `TAM_PTR_CTRL:  rdata_d = ctrl_view;
      `TAM_PTR_UPPER: rdata_d = {3'b000, upper_q, 2'b00};
      `TAM_PTR_LOWER: rdata_d = {3'b000, lower_q, 2'b00};
      `TAM_PTR_CRIT:  rdata_d = {3'b000, crit_q, 2'b00};
      default:        rdata_d = 16'h0000;
    endcase
  end

  // Read word is captured on the strobe and held until the next
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= i_rd_stb;
      if (i_rd_stb)
        rdata_q <= rdata_d;
    end
  end

  assign o_rd_data  = rdata_q;
  assign o_rd_valid = rvalid_q;

endmodule

// ==== verilog/tam_hyst_cmp.v ====
// Purpose: One limit comparator with falling-side hysteresis
// Assumes: Quarter-degree two's complement values, sampled by a strobe
// Notes:   Flag holds between samples, so shutdown freezes it
module tam_hyst_cmp #(
  parameter BELOW = 0
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_sample,
  input  wire [10:0] i_temp,
  input  wire [10:0] i_limit,
  input  wire [12:0] i_hyst,
  output wire        o_flag
);

  reg         flag_q;
  wire signed [12:0] temp_s;
  wire signed [12:0] lim_s;
  wire signed [12:0] lim_h_s;

  // Sign-extend two bits so the subtraction cannot wrap
  assign temp_s  = {{2{i_temp[10]}}, i_temp};
  assign lim_s   = {{2{i_limit[10]}}, i_limit};
  assign lim_h_s = lim_s - $signed(i_hyst);

  // Above: set over limit, clear at or under limit minus hyst
  // Below: set under limit minus hyst, clear at or over limit
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      flag_q <= 1'b0;
    else if (i_sample)
    begin
      if (BELOW == 0)
      begin
        if (temp_s > lim_s)
          flag_q <= 1'b1;
        else if (temp_s <= lim_h_s)
          flag_q <= 1'b0;
      end
      else
      begin
        if (temp_s < lim_h_s)
          flag_q <= 1'b1;
        else if (temp_s >= lim_s)
          flag_q <= 1'b0;
      end
    end
  end

  assign o_flag = flag_q;

endmodule

// ==== verilog/tam_map.vh ====
// Purpose: Register map and field layout of the thermal alarm block
// Assumes: 16-bit registers reached through an 8-bit pointer
// Notes:   Definitions only
`ifndef TAM_MAP_VH
`define TAM_MAP_VH

// Pointer values
`define TAM_PTR_CTRL        8'h01
`define TAM_PTR_UPPER       8'h02
`define TAM_PTR_LOWER       8'h03
`define TAM_PTR_CRIT        8'h04
`define TAM_PTR_RESET       8'h00

// Reset values
`define TAM_CTRL_RESET      16'h0000
`define TAM_LIMIT_RESET     11'h000

// Control field positions
`define TAM_HYST_HI         10
`define TAM_HYST_LO         9
`define TAM_POWER_DOWN      8
`define TAM_CRIT_LOCK       7
`define TAM_WIN_LOCK        6
`define TAM_RELEASE         5
`define TAM_ASSERTED_FLAG   4
`define TAM_ALARM_EN        3
`define TAM_CRIT_ONLY       2
`define TAM_POLARITY        1
`define TAM_IRQ_MODE        0

// Limit field: sign at bit 12, quarter degree at bit 2
`define TAM_LIM_HI          12
`define TAM_LIM_LO          2

// Hysteresis in quarter degrees: 0, 1.5, 3, 6 degC
`define TAM_HYST_NONE       13'h0000
`define TAM_HYST_1P5        13'h0006
`define TAM_HYST_3          13'h000C
`define TAM_HYST_6          13'h0018

`endif
